// [pkg/smc_pkg.sv]
/*
  Constants, state types and timing figures for the operating-mode
  controller of a system basis chip.
  Assumes a single 25 MHz core clock and no register bus.
*/
// Functional notes
// - Init samples strap pin with pull-up enabled
// - Strap low: development, test flag, no watchdog reset
// - Config 1: first missed trigger restarts, fail outputs
// - Config 3: second missed trigger restarts, fail outputs
// - Config-select bit picks config 1 or 3
// - Init waits reset delay, releases reset, long window
// - Any SPI frame in Init after reset release goes to Normal
// - Missed long window: counted as a missed trigger under config 1/3
// - Limit bit stops resets after three consecutive
// - Wake events in Init are discarded
// - Below threshold before first reset release: hold reset, hide undervoltage, fails
// - Normal/Stop wake raises interrupt, mode unchanged
// - Init to Normal: VCC2 and transceivers off, fails inactive
// - Normal allows fail-output test bit control
// - Stop ignores writes except allowed, sets SPI fail
// - Stop/Sleep freeze supply and wake settings
// - Stop to Sleep refused: SPI fail, Restart
// - Sleep: main supply off, wake restarts, record source
// - Sleep entry turns active transceivers wake-capable
// - Sleep ignores all SPI frames silently
// - Sleep request with wake flags set restarts
// - Reset output low on Sleep request
// - Mode bits cleared passing through Restart
// - Restart to Normal after reset delay, release reset
package smc_pkg;

  // Operating modes
  typedef enum logic [2:0] {
    SMC_INIT,
    SMC_NORMAL,
    SMC_STOP,
    SMC_SLEEP,
    SMC_RESTART
  } smc_mode_type;

  // Mode request codes carried by a mode frame
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_STOP = 2'h2;
  localparam logic [1:0] REQ_SOFTRST = 2'h3;

  // Transceiver mode codes
  localparam logic [1:0] TRX_OFF = 2'h0;
  localparam logic [1:0] TRX_WAKE = 2'h1;
  localparam logic [1:0] TRX_RXONLY = 2'h2;
  localparam logic [1:0] TRX_NORMAL = 2'h3;

  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int RESET_DELAY_US = 10;
  localparam int RESET_DELAY_CYC = RESET_DELAY_US * (CLK_HZ / 1000000);
  localparam int LONG_WINDOW_MS = 200;
  localparam int LONG_WINDOW_CYC = LONG_WINDOW_MS * (CLK_HZ / 1000);
  localparam int MAX_WD_RESETS = 3;

  // Reset values
  localparam logic [1:0] WD_CNT_RST = 2'h0;

endpackage

// [design/smc_delay_timer.sv]
/*
  Down-counting delay timer: load starts a count, done pulses once it
  reaches zero.
  Assumes load has priority over the running count.
*/
`timescale 1ns/10ps
module smc_delay_timer import smc_pkg::*; #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  input wire logic stop,
  // Status
  output logic running,
  output logic done
);

  initial begin
    if (WIDTH < 2) $error("smc_delay_timer: WIDTH too small");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic run;
    logic done;
  } smc_tmr_type;

  smc_tmr_type st_r;
  smc_tmr_type st_nxt;

  // Counter update
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (load) begin
      st_nxt.cnt = loadValue;
      st_nxt.run = 1'b1;
    end else if (stop) begin
      st_nxt.run = 1'b0;
    end else if (st_r.run) begin
      if (st_r.cnt <= WIDTH'(1)) begin
        st_nxt.run = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign running = st_r.run;
  assign done = st_r.done;

endmodule

// [design/smc_strap_sampler.sv]
/*
  Strap sampler: drives the pull-up during Init, while the controller tristates the shared pin,
  and latches the pin level at the end of the sampling period.
  Assumes the pin input is synchronous to core_clk.
*/
`timescale 1ns/10ps
module smc_strap_sampler import smc_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic inInit,
  input wire logic capture,
  input wire logic softReset,
  input wire logic strapIn,
  // Result
  output logic pullupEn,
  output logic devMode
);

  typedef struct packed {
    logic dev;
    logic locked;
  } smc_strap_type;

  smc_strap_type st_r;
  smc_strap_type st_nxt;

  // Capture the strap once; a soft reset forbids development mode
  always_comb begin
    st_nxt = st_r;
    if (softReset) begin
      st_nxt.dev = 1'b0;
      st_nxt.locked = 1'b1;
    end else if (capture && inInit && !st_r.locked) begin
      st_nxt.dev = !strapIn;
      st_nxt.locked = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pullupEn = inInit;
  assign devMode = st_r.dev;

endmodule

// [design/smc_mode_ctrl.sv]
/*
  Operating-mode controller: Init, Normal, Stop, Sleep and Restart,
  watchdog failure handling, SPI frame filtering and wake interrupts.
  Assumes the SPI decoder, watchdog timer, supply monitor and wake
  detectors are outside and deliver one-cycle pulses or levels here.
*/
`timescale 1ns/10ps
module smc_mode_ctrl import smc_pkg::*; #(
  parameter int RESET_DELAY = RESET_DELAY_CYC,
  parameter int LONG_WINDOW = LONG_WINDOW_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Supply monitor
  input wire logic vcc1AboveThr,
  // Strap pin
  input wire logic failOut3StrapIn,
  output logic failOut3StrapOut,
  output logic failOut3StrapOe,
  output logic strapPullupEn,
  // Decoded SPI frames
  input wire logic spiFrame,
  input wire logic spiWrite,
  input wire logic spiModeReq,
  input wire logic [1:0] spiModeCode,
  input wire logic spiWdRefresh,
  input wire logic spiSysStatWrite,
  input wire logic spiStatusAccess,
  input wire logic spiCfgWrite,
  // Configuration written by software
  input wire logic configSelectBit,
  input wire logic max3RstBit,
  input wire logic failOutputTest,
  input wire logic vcc2EnReq,
  input wire logic [1:0] canModeReq,
  input wire logic [1:0] lin1ModeReq,
  input wire logic [1:0] lin2ModeReq,
  input wire logic wakePinEnReq,
  input wire logic cyclicWakeEnReq,
  // Watchdog and wake
  input wire logic wdMissed,
  input wire logic wakeCan,
  input wire logic wakeLin1,
  input wire logic wakeLin2,
  input wire logic wakePin,
  input wire logic wakeFlagsClear,
  // Mode and supply control
  output smc_mode_type mode,
  output logic [1:0] modeBits,
  output logic resetOutputN,
  output logic interruptOut,
  output logic vcc1En,
  output logic boostEn,
  output logic vcc2En,
  output logic [1:0] canMode,
  output logic [1:0] lin1Mode,
  output logic [1:0] lin2Mode,
  output logic wakePinEn,
  output logic cyclicWakeEn,
  output logic failSafeInputEn,
  // Status
  output logic failOutputs,
  output logic testIndicator,
  output logic configSelectState,
  output logic wdFail,
  output logic spiFail,
  output logic mainSupplyUvFlag,
  output logic [3:0] wakeSource,
  output logic spiRespEn,
  output logic longWindowOpen
);

  initial begin
    if (RESET_DELAY < 1 || LONG_WINDOW < 1) begin
      $error("smc_mode_ctrl: delays must be at least one cycle");
    end
  end

  localparam int TW = 32;

  typedef struct packed {
    smc_mode_type mode;
    logic [1:0] modeBits;
    logic rstOutN;
    logic irq;
    logic vcc2;
    logic [1:0] can;
    logic [1:0] lin1;
    logic [1:0] lin2;
    logic wkEn;
    logic cyc;
    logic fsiEn;
    logic fail;
    logic [1:0] missCnt;
    logic [1:0] rstCnt;
    logic wdFail;
    logic spiFail;
    logic uv;
    logic [3:0] wakeSrc;
    logic released;
    logic seenAbove;
  } smc_state_type;

  smc_state_type st_r;
  smc_state_type st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  logic tmrLoad;
  logic [TW-1:0] tmrValue;
  logic tmrDone;
  logic winLoad;
  logic winStop;
  logic winRun;
  logic winDone;
  logic strapCapture;
  logic softRst;
  logic devMode;

  smc_delay_timer #(.WIDTH(TW)) uDelay (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(tmrLoad),
    .loadValue(tmrValue),
    .stop(1'b0),
    .running(),
    .done(tmrDone)
  );

  smc_delay_timer #(.WIDTH(TW)) uWindow (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(winLoad),
    .loadValue(TW'(LONG_WINDOW)),
    .stop(winStop),
    .running(winRun),
    .done(winDone)
  );

  smc_strap_sampler uStrap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inInit(st_r.mode == SMC_INIT),
    .capture(strapCapture),
    .softReset(softRst),
    .strapIn(failOut3StrapIn),
    .pullupEn(strapPullupEn),
    .devMode(devMode)
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame classification

  logic anyWake;
  logic stopAllowed;
  logic missEffective;
  logic failNow;

  assign anyWake = wakeCan | wakeLin1 | wakeLin2 | wakePin;
  // Writes that Stop mode still honours
  assign stopAllowed = (spiModeReq && (spiModeCode == REQ_NORMAL ||
                       spiModeCode == REQ_SOFTRST)) || spiWdRefresh ||
                       spiSysStatWrite || spiStatusAccess;
  assign softRst = spiFrame && spiModeReq && spiModeCode == REQ_SOFTRST &&
                   (st_r.mode == SMC_NORMAL || st_r.mode == SMC_STOP);
  // Missed trigger or expired long window, ignored in development
  assign missEffective = (wdMissed || winDone) && !devMode;
  // Config 1 fails on first miss, config 3 on second
  assign failNow = missEffective &&
                   (configSelectBit || st_r.missCnt != 2'h0);

  // Init delay expiry captures the strap and starts the long window; a refresh frame stops it
  assign strapCapture = tmrDone && st_r.mode == SMC_INIT;
  assign winLoad = tmrDone && st_r.mode == SMC_INIT;
  assign winStop = spiWdRefresh && spiFrame;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    st_nxt = st_r;
    tmrLoad = 1'b0;
    tmrValue = TW'(RESET_DELAY);
    if (!vcc1AboveThr) begin
      st_nxt.seenAbove = 1'b0;
    end
    case (st_r.mode)
      SMC_INIT: begin
        // Hold reset and suppress flags until threshold, then delay
        st_nxt.rstOutN = st_r.released;
        if (vcc1AboveThr && !st_r.seenAbove) begin
          st_nxt.seenAbove = 1'b1;
          tmrLoad = 1'b1;
        end
        if (tmrDone) begin
          st_nxt.released = 1'b1;
          st_nxt.rstOutN = 1'b1;
        end
        // Wake events are simply not looked at here
        if (spiFrame && st_r.released) begin
          st_nxt.mode = SMC_NORMAL;
          st_nxt.vcc2 = 1'b0;
          st_nxt.can = TRX_OFF;
          st_nxt.lin1 = TRX_OFF;
          st_nxt.lin2 = TRX_OFF;
          st_nxt.fail = 1'b0;
          st_nxt.fsiEn = 1'b1;
        end else if (failNow && st_r.released) begin
          st_nxt.mode = SMC_RESTART;
          st_nxt.wdFail = 1'b1;
          st_nxt.fail = 1'b1;
          st_nxt.rstOutN = 1'b0;
          st_nxt.modeBits = REQ_NORMAL;
          tmrLoad = 1'b1;
        end
        if (missEffective && !failNow) begin
          st_nxt.missCnt = st_r.missCnt + 2'h1;
        end
      end
      SMC_NORMAL, SMC_STOP: begin
        if (st_r.mode == SMC_NORMAL) begin
          // Live configuration; frozen in Stop and Sleep
          st_nxt.vcc2 = vcc2EnReq;
          st_nxt.can = canModeReq;
          st_nxt.lin1 = lin1ModeReq;
          st_nxt.lin2 = lin2ModeReq;
          st_nxt.wkEn = wakePinEnReq;
          st_nxt.cyc = cyclicWakeEnReq;
          if (spiFrame && spiCfgWrite) begin
            st_nxt.fail = failOutputTest;
          end
        end
        if (anyWake) begin
          st_nxt.irq = 1'b1;
        end else if (spiFrame && spiStatusAccess) begin
          st_nxt.irq = 1'b0;
        end
        if (missEffective && !failNow) begin
          st_nxt.missCnt = st_r.missCnt + 2'h1;
        end
        if (spiFrame && (spiWrite || spiModeReq) && st_r.mode == SMC_STOP &&
            !stopAllowed) begin
          st_nxt.spiFail = 1'b1;
          if (spiModeReq && spiModeCode == REQ_SLEEP) begin
            st_nxt.mode = SMC_RESTART;
            st_nxt.rstOutN = 1'b0;
            st_nxt.modeBits = REQ_NORMAL;
            tmrLoad = 1'b1;
          end
        end else if (failNow) begin
          if (max3RstBit && st_r.rstCnt == 2'(MAX_WD_RESETS)) begin
            st_nxt.wdFail = 1'b1;
          end else begin
            st_nxt.mode = SMC_RESTART;
            st_nxt.wdFail = 1'b1;
            st_nxt.fail = 1'b1;
            st_nxt.rstOutN = 1'b0;
            st_nxt.modeBits = REQ_NORMAL;
            st_nxt.missCnt = 2'h0;
            if (st_r.rstCnt != 2'(MAX_WD_RESETS)) begin
              st_nxt.rstCnt = st_r.rstCnt + 2'h1;
            end
            tmrLoad = 1'b1;
          end
        end else if (spiFrame && spiModeReq) begin
          st_nxt.modeBits = spiModeCode;
          if (spiModeCode == REQ_STOP) begin
            st_nxt.mode = SMC_STOP;
          end else if (spiModeCode == REQ_NORMAL) begin
            st_nxt.mode = SMC_NORMAL;
          end else if (spiModeCode == REQ_SOFTRST) begin
            st_nxt = '0;
            st_nxt.mode = SMC_INIT;
          end else begin
            st_nxt.rstOutN = 1'b0;
            st_nxt.rstCnt = 2'h0;
            if (!wakeFlagsClear) begin
              st_nxt.mode = SMC_RESTART;
              st_nxt.modeBits = REQ_NORMAL;
              tmrLoad = 1'b1;
            end else begin
              st_nxt.mode = SMC_SLEEP;
              // Active transceivers become wake sources
              if (st_r.can[1]) st_nxt.can = TRX_WAKE;
              if (st_r.lin1[1]) st_nxt.lin1 = TRX_WAKE;
              if (st_r.lin2[1]) st_nxt.lin2 = TRX_WAKE;
            end
          end
        end else if (spiWdRefresh && spiFrame) begin
          st_nxt.rstCnt = 2'h0;
          st_nxt.missCnt = 2'h0;
        end
      end
      SMC_SLEEP: begin
        // SPI frames ignored any wake restarts
        if (anyWake) begin
          st_nxt.wakeSrc = {wakePin, wakeLin2, wakeLin1, wakeCan};
          st_nxt.mode = SMC_RESTART;
          st_nxt.modeBits = REQ_NORMAL;
          tmrLoad = 1'b1;
        end
      end
      SMC_RESTART: begin
        st_nxt.rstOutN = 1'b0;
        st_nxt.vcc2 = 1'b0;
        if (!vcc1AboveThr) begin
          tmrLoad = 1'b1;
        end else if (tmrDone) begin
          st_nxt.mode = SMC_NORMAL;
          st_nxt.rstOutN = 1'b1;
        end
      end
      default: st_nxt.mode = SMC_INIT;
    endcase
    // Undervoltage only after reset has first been released at the end of the delay
    if (st_r.released && !vcc1AboveThr) begin
      st_nxt.uv = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign mode = st_r.mode;
  assign modeBits = st_r.modeBits;
  assign resetOutputN = st_r.rstOutN;
  assign interruptOut = st_r.irq;
  assign vcc1En = st_r.mode != SMC_SLEEP;
  assign boostEn = st_r.mode != SMC_SLEEP;
  assign vcc2En = st_r.vcc2;
  assign canMode = st_r.can;
  assign lin1Mode = st_r.lin1;
  assign lin2Mode = st_r.lin2;
  assign wakePinEn = st_r.wkEn;
  assign cyclicWakeEn = st_r.cyc;
  assign failSafeInputEn = st_r.fsiEn;
  assign failOutputs = st_r.fail;
  assign testIndicator = devMode;
  assign configSelectState = configSelectBit;
  assign wdFail = st_r.wdFail;
  assign spiFail = st_r.spiFail;
  assign mainSupplyUvFlag = st_r.uv;
  assign wakeSource = st_r.wakeSrc;
  assign spiRespEn = st_r.mode != SMC_SLEEP && st_r.mode != SMC_RESTART;
  assign longWindowOpen = winRun;
  // Strap pin only driven as fail output outside Init
  assign failOut3StrapOe = st_r.mode != SMC_INIT && st_r.fail;
  assign failOut3StrapOut = 1'b0;

endmodule

// [bench/smc_mode_ctrl_asserts.sv]
/*
  Checker for the operating-mode controller: mode changes, reset output,
  wake interrupts and supply control seen at the top ports.
  Assumes bound to smc_mode_ctrl with the bench's shortened delays.
*/
`timescale 1ns/10ps
module smc_mode_asserts import smc_pkg::*; #(
  parameter int RESET_DELAY = 5,
  parameter int LONG_WINDOW = 50
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Inputs of the block
  input wire logic vcc1AboveThr,
  input wire logic spiFrame,
  input wire logic spiModeReq,
  input wire logic [1:0] spiModeCode,
  input wire logic wakeCan,
  input wire logic wakeLin1,
  input wire logic wakeLin2,
  input wire logic wakePin,
  // Outputs of the block
  input wire smc_mode_type mode,
  input wire logic resetOutputN,
  input wire logic interruptOut,
  input wire logic vcc1En,
  input wire logic boostEn,
  input wire logic vcc2En,
  input wire logic [1:0] canMode,
  input wire logic spiFail,
  input wire logic [3:0] wakeSource
);
  localparam int RD_HI = RESET_DELAY + 4;
  ////////////////////////////////////////////////////////////////////////
  // Helper terms
  wire anyWake = wakeCan | wakeLin1 | wakeLin2 | wakePin;
  wire sleepReq = spiFrame && spiModeReq && spiModeCode == REQ_SLEEP;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_init_frame_normal: assert property (
    mode == SMC_INIT && resetOutputN && spiFrame && !spiModeReq
    |=> mode == SMC_NORMAL) else $error("Init frame did not give Normal");
  a_low_supply_reset: assert property (
    !vcc1AboveThr && mode == SMC_INIT |=> !resetOutputN)
    else $error("Reset released below threshold");
  a_reset_delay: assert property (
    $rose(vcc1AboveThr) && mode == SMC_INIT
    |-> ##[RESET_DELAY:RD_HI] $rose(resetOutputN))
    else $error("Reset release not after the delay");
  a_wake_irq: assert property (
    (mode == SMC_NORMAL || mode == SMC_STOP) && anyWake && !spiFrame
    |=> interruptOut && $stable(mode)) else $error("Wake gave no interrupt");
  a_init_wake_lost: assert property (
    mode == SMC_INIT && anyWake |=> !interruptOut)
    else $error("Wake in Init raised interrupt");
  a_stop_sleep_refused: assert property (
    mode == SMC_STOP && sleepReq |=> spiFail && mode == SMC_RESTART)
    else $error("Stop to Sleep not refused");
  a_sleep_req_reset: assert property (
    mode == SMC_NORMAL && sleepReq |=> !resetOutputN)
    else $error("Reset not low after Sleep request");
  a_sleep_supply_off: assert property (
    mode == SMC_SLEEP |-> !vcc1En && !boostEn)
    else $error("Main supply on in Sleep");
  a_sleep_wake_restart: assert property (
    mode == SMC_SLEEP && anyWake |=> mode == SMC_RESTART && wakeSource != 0)
    else $error("Sleep wake not handled");
  a_sleep_can_wake: assert property (
    mode == SMC_SLEEP |-> canMode != TRX_NORMAL && canMode != TRX_RXONLY)
    else $error("CAN active in Sleep");
  a_stop_frozen: assert property (
    mode == SMC_STOP && $past(mode) == SMC_STOP
    |-> $stable(canMode) && $stable(vcc2En)) else $error("Stop not frozen");
  a_restart_ro_low: assert property (
    mode == SMC_RESTART && $past(mode) == SMC_RESTART |-> !resetOutputN)
    else $error("Reset high in Restart");
  // Main scenarios reached
  c_init_normal: cover property (mode == SMC_INIT ##1 mode == SMC_NORMAL);
  c_sleep_wake: cover property (mode == SMC_SLEEP ##1 mode == SMC_RESTART);
  c_stop_sleep: cover property (mode == SMC_STOP && sleepReq);
endmodule

// [bench/smc_host_model.sv]
/*
  Host microcontroller model: issues decoded SPI frames and keeps the
  wake-flag state it has cleared.
  Assumes frames are one clock long and qualifiers valid with them.
*/
`timescale 1ns/10ps
module smc_host_model import smc_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Decoded frame
  output logic spiFrame,
  output logic spiWrite,
  output logic spiModeReq,
  output logic [1:0] spiModeCode,
  output logic spiWdRefresh,
  output logic spiSysStatWrite,
  output logic spiStatusAccess,
  output logic spiCfgWrite,
  // Wake flag state
  output logic wakeFlagsClear
);
  initial begin
    spiFrame = 1'b0;
    wakeFlagsClear = 1'b0;
    {spiWrite, spiModeReq, spiModeCode, spiWdRefresh, spiSysStatWrite,
     spiStatusAccess, spiCfgWrite} = 8'h00;
  end
  // One frame; qualifiers invert once released so stale values never match
  task automatic send(input logic [7:0] q);
    @(posedge core_clk);
    spiFrame <= 1'b1;
    {spiWrite, spiModeReq, spiModeCode, spiWdRefresh, spiSysStatWrite,
     spiStatusAccess, spiCfgWrite} <= q;
    @(posedge core_clk);
    spiFrame <= 1'b0;
    {spiWrite, spiModeReq, spiModeCode, spiWdRefresh, spiSysStatWrite,
     spiStatusAccess, spiCfgWrite} <= ~q;
    #1;
  endtask
  // Watchdog trigger inside the open window
  task automatic refresh;
    send(8'h88);
  endtask
  // Wake flags cleared, or left set, before a Sleep request
  task automatic flags(input logic clr);
    @(posedge core_clk);
    wakeFlagsClear <= clr;
  endtask
endmodule

// [bench/tb_top.sv]
/*
  Testbench for the operating-mode controller: start-up, mode changes,
  watchdog failure handling and wake behaviour.
  Assumes smc_pkg compiled first and shortened delays of 5 and 50.
*/
`timescale 1ns/10ps
module tb_top import smc_pkg::*;;
  logic core_clk = 1'b0, rst_n, vcc1AboveThr, strapGnd;
  logic configSelectBit, max3RstBit, failOutputTest;
  logic vcc2EnReq, wakePinEnReq, cyclicWakeEnReq, wdMissed;
  logic wakeCan = 0, wakeLin1 = 0, wakeLin2 = 0, wakePin = 0;
  logic [1:0] canModeReq, lin1ModeReq, lin2ModeReq;
  logic spiFrame, spiWrite, spiModeReq, spiWdRefresh, spiSysStatWrite;
  logic spiStatusAccess, spiCfgWrite, wakeFlagsClear, failOut3StrapIn;
  logic failOut3StrapOut, failOut3StrapOe, strapPullupEn, resetOutputN;
  logic interruptOut, vcc1En, boostEn, vcc2En, wakePinEn, cyclicWakeEn;
  logic failSafeInputEn, failOutputs, testIndicator, configSelectState;
  logic wdFail, spiFail, mainSupplyUvFlag, spiRespEn, longWindowOpen;
  logic [1:0] spiModeCode, modeBits, canMode, lin1Mode, lin2Mode;
  logic [3:0] wakeSource;
  smc_mode_type mode;
  int fails = 0, compares = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock, strap pin level and instances
  always #20 core_clk = ~core_clk;
  assign failOut3StrapIn = strapGnd ? 1'b0 :
                           (failOut3StrapOe ? failOut3StrapOut : strapPullupEn);
  smc_mode_ctrl #(.RESET_DELAY(5), .LONG_WINDOW(50)) DUT (.*);
  smc_host_model host (.*);
  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string n, input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_mode(input smc_mode_type m);
    for (int i = 0; i < 60 && mode !== m; i++) tick(1);
    chk("mode", mode, m);
  endtask
  task automatic wake(input logic [3:0] w);
    @(posedge core_clk);
    {wakePin, wakeLin2, wakeLin1, wakeCan} <= w;
    @(posedge core_clk);
    {wakePin, wakeLin2, wakeLin1, wakeCan} <= 4'h0;
    #1;
  endtask
  task automatic miss;
    @(posedge core_clk);
    wdMissed <= 1'b1;
    @(posedge core_clk);
    wdMissed <= 1'b0;
    #1;
  endtask
  // Wait for reset release, then leave Init with an illegal frame
  task automatic leave_init;
    for (int i = 0; i < 40 && resetOutputN !== 1'b1; i++) tick(1);
    chk("rst_rel", resetOutputN, 1'b1);
    chk("long_win", longWindowOpen, 1'b1);
    wake(4'h1);
    chk("init_irq", interruptOut, 1'b0);
    host.send(8'h00);
    wait_mode(SMC_NORMAL);
    host.refresh();
  endtask
  task automatic power_up(input logic gnd, sel, lim);
    rst_n <= 1'b0;
    vcc1AboveThr <= 1'b0;
    {strapGnd, configSelectBit, max3RstBit} <= {gnd, sel, lim};
    {canModeReq, lin1ModeReq, lin2ModeReq, vcc2EnReq} <= 7'h00;
    {wdMissed, failOutputTest, wakePinEnReq, cyclicWakeEnReq} <= 4'h0;
    tick(4);
    rst_n <= 1'b1;
    tick(2);
    chk("rst_low", resetOutputN, 1'b0);
    chk("uv_flag", mainSupplyUvFlag, 1'b0);
    chk("pullup", strapPullupEn, 1'b1);
    chk("strap_oe", failOut3StrapOe, 1'b0);
    vcc1AboveThr <= 1'b1;
    leave_init();
    chk("test_ind", testIndicator, gnd);
    if (!gnd) chk("cfg_state", configSelectState, sel);
    chk("vcc2", vcc2En, 1'b0);
    chk("can", canMode, TRX_OFF);
    chk("fail_out", failOutputs, 1'b0);
    chk("fsi", failSafeInputEn, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_normal;
    failOutputTest <= 1'b1;
    host.send(8'h81);
    chk("fo_test_on", failOutputs, 1'b1);
    failOutputTest <= 1'b0;
    host.send(8'h81);
    chk("fo_test_off", failOutputs, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wake(4'h1 << i);
      chk("irq", interruptOut, 1'b1);
      chk("irq_mode", mode, SMC_NORMAL);
      host.send(8'h02);
      tick(1);
      chk("irq_clr", interruptOut, 1'b0);
    end
  endtask
  task automatic t_stop;
    {canModeReq, vcc2EnReq} <= {TRX_RXONLY, 1'b1};
    tick(2);
    host.send(8'he0);
    wait_mode(SMC_STOP);
    {canModeReq, vcc2EnReq} <= {TRX_NORMAL, 1'b0};
    tick(3);
    chk("can_frozen", canMode, TRX_RXONLY);
    chk("vcc2_frozen", vcc2En, 1'b1);
    host.refresh();
    host.send(8'h02);
    tick(1);
    chk("stop_ok", spiFail, 1'b0);
    host.send(8'h81);
    tick(1);
    chk("stop_wr", spiFail, 1'b1);
    chk("stop_mode", mode, SMC_STOP);
    host.send(8'hc0);
    wait_mode(SMC_NORMAL);
    host.refresh();
  endtask
  task automatic t_refuse;
    host.send(8'he0);
    wait_mode(SMC_STOP);
    host.send(8'hd0);
    tick(1);
    chk("refuse_fail", spiFail, 1'b1);
    chk("refuse_mode", mode, SMC_RESTART);
    wait_mode(SMC_NORMAL);
    chk("ro_back", resetOutputN, 1'b1);
    chk("mode_bits", modeBits, REQ_NORMAL);
    host.refresh();
  endtask
  task automatic t_sleep;
    {canModeReq, lin1ModeReq} <= {TRX_NORMAL, TRX_RXONLY};
    host.flags(1'b1);
    tick(2);
    host.send(8'hd0);
    tick(1);
    chk("sleep_ro", resetOutputN, 1'b0);
    wait_mode(SMC_SLEEP);
    chk("sleep_can", canMode, TRX_WAKE);
    chk("sleep_lin", lin1Mode, TRX_WAKE);
    chk("sleep_vcc1", {vcc1En, boostEn}, 2'h0);
    host.send(8'hc0);
    tick(2);
    chk("sleep_spi", {mode, spiRespEn}, {SMC_SLEEP, 1'b0});
    wake(4'h2);
    chk("wake_mode", mode, SMC_RESTART);
    chk("wake_src", wakeSource, 4'h2);
    wait_mode(SMC_NORMAL);
    host.refresh();
    host.flags(1'b0);
    host.send(8'hd0);
    tick(1);
    chk("flags_set", mode, SMC_RESTART);
    wait_mode(SMC_NORMAL);
    host.refresh();
  endtask
  task automatic t_wd;
    miss();
    chk("wd_fail", wdFail, 1'b1);
    chk("cfg1_mode", mode, SMC_RESTART);
    chk("cfg1_fo", {failOutputs, vcc1En}, 2'h3);
    for (int i = 0; i < 2; i++) begin
      wait_mode(SMC_NORMAL);
      miss();
      chk("lim_rst", mode, SMC_RESTART);
    end
    wait_mode(SMC_NORMAL);
    miss();
    tick(2);
    chk("lim_stop", {mode, resetOutputN}, {SMC_NORMAL, 1'b1});
  endtask
  task automatic t_cfg3;
    miss();
    tick(2);
    chk("cfg3_first", {mode, failOutputs}, {SMC_NORMAL, 1'b0});
    miss();
    chk("cfg3_second", {mode, failOutputs}, {SMC_RESTART, 1'b1});
  endtask
  task automatic t_dev;
    miss();
    tick(2);
    chk("dev_wd", {mode, resetOutputN}, {SMC_NORMAL, 1'b1});
    host.send(8'hf0);
    wait_mode(SMC_INIT);
    leave_init();
    chk("dev_lost", testIndicator, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict, hang guard and main sequence
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    power_up(1'b0, 1'b1, 1'b0);
    t_normal();
    t_stop();
    power_up(1'b0, 1'b1, 1'b0);
    t_refuse();
    t_sleep();
    power_up(1'b0, 1'b1, 1'b1);
    t_wd();
    power_up(1'b0, 1'b0, 1'b0);
    t_cfg3();
    power_up(1'b1, 1'b1, 1'b0);
    t_dev();
    close_out();
  end
endmodule
bind smc_mode_ctrl smc_mode_asserts #(.RESET_DELAY(5), .LONG_WINDOW(50))
  chk (.*);
